// ==== common/nfc_defs.vh ====
`ifndef NFC_DEFS_VH
`define NFC_DEFS_VH
// ============================================================
// Command codes
`define NFC_CMD_READ1      8'h00
`define NFC_CMD_READ2      8'h50
`define NFC_CMD_COPYBACK   8'h8a
`define NFC_CMD_ERASE_SET  8'h60
`define NFC_CMD_ERASE_GO   8'hd0
`define NFC_CMD_STATUS     8'h70
`define NFC_CMD_IDENT      8'h90
`define NFC_CMD_RESET      8'hff
`define NFC_CMD_LOCK_ALL   8'h2a
`define NFC_CMD_UNLOCK_LO  8'h23
`define NFC_CMD_UNLOCK_HI  8'h24
`define NFC_CMD_STICKY     8'h2c
// ============================================================
// User operation codes
`define NFC_OP_COPYBACK    3'h0
`define NFC_OP_ERASE       3'h1
`define NFC_OP_STATUS      3'h2
`define NFC_OP_IDENT       3'h3
`define NFC_OP_RESET       3'h4
`define NFC_OP_LOCK_ALL    3'h5
`define NFC_OP_UNLOCK      3'h6
`define NFC_OP_STICKY      3'h7
// ============================================================
// Status byte fields
`define NFC_ST_FAIL        0
`define NFC_ST_READY       6
`define NFC_ST_NOT_WP      7
`define NFC_ST_RESET_VAL   8'hc0
// ============================================================
// Address layout: row address bits start at A9
`define NFC_PLANE_BIT      5
`define NFC_BLOCK_LSB      5
// ============================================================
// Pin timing in ns, and derived cycle counts at 10 ns
`define NFC_CLK_NS         10
`define NFC_STROBE_NS      30
`define NFC_STROBE_CYC     ((`NFC_STROBE_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_BUSY_WAIT_NS   100
`define NFC_BUSY_WAIT_CYC  ((`NFC_BUSY_WAIT_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`endif

// ==== logic/nfc_seq_rom.v ====
`timescale 1ns/10ps
`include "nfc_defs.vh"
// ============================================================
// Cycle script per operation: registered read of {kind,data}
// kind: 0 cmd, 1 addr, 2 wait ready, 3 read, 4 end, 5 poll status
module nfc_seq_rom (
	input  wire        mclk,
	input  wire        reset_n,
	input  wire [2:0]  op,
	input  wire [3:0]  step,
	input  wire [23:0] row,
	input  wire [23:0] row2,
	output reg  [2:0]  kind,
	output reg  [7:0]  data
);
	// ============================================================
	// Script lookup
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			kind <= 3'h4;
			data <= 8'h00;
		end else begin
			kind <= 3'h4;
			data <= 8'h00;
			case (op)
			`NFC_OP_COPYBACK: begin
				// Source read fills the page buffer; program only once it is ready
				case (step)
				4'h0: begin kind <= 3'h0; data <= `NFC_CMD_READ1; end
				4'h1: begin kind <= 3'h1; data <= 8'h00; end
				4'h2: begin kind <= 3'h1; data <= row[7:0]; end
				4'h3: begin kind <= 3'h1; data <= row[15:8]; end
				4'h4: kind <= 3'h2;
				4'h5: begin kind <= 3'h0; data <= `NFC_CMD_COPYBACK; end
				4'h6: begin kind <= 3'h1; data <= 8'h00; end
				4'h7: begin kind <= 3'h1; data <= row2[7:0]; end
				4'h8: begin kind <= 3'h1; data <= row2[15:8]; end
				4'h9: kind <= 3'h2;
				default: ;
				endcase
			end
			`NFC_OP_ERASE: begin
				case (step)
				4'h0: begin kind <= 3'h0; data <= `NFC_CMD_ERASE_SET; end
				4'h1: begin kind <= 3'h1; data <= {row[7:5], 5'h00}; end
				4'h2: begin kind <= 3'h1; data <= row[15:8]; end
				4'h3: begin kind <= 3'h0; data <= `NFC_CMD_ERASE_GO; end
				4'h4: begin kind <= 3'h5; data <= `NFC_CMD_STATUS; end
				default: ;
				endcase
			end
			`NFC_OP_STATUS: begin
				case (step)
				4'h0: begin kind <= 3'h0; data <= `NFC_CMD_STATUS; end
				4'h1: kind <= 3'h3;
				default: ;
				endcase
			end
			`NFC_OP_IDENT: begin
				case (step)
				4'h0: begin kind <= 3'h0; data <= `NFC_CMD_IDENT; end
				4'h1: begin kind <= 3'h1; data <= 8'h00; end
				4'h2: kind <= 3'h3;
				4'h3: kind <= 3'h3;
				default: ;
				endcase
			end
			`NFC_OP_RESET: begin
				case (step)
				4'h0: begin kind <= 3'h0; data <= `NFC_CMD_RESET; end
				4'h1: kind <= 3'h2;
				default: ;
				endcase
			end
			`NFC_OP_LOCK_ALL: begin
				if (step == 4'h0) begin
					kind <= 3'h0;
					data <= `NFC_CMD_LOCK_ALL;
				end
			end
			`NFC_OP_UNLOCK: begin
				case (step)
				4'h0: begin kind <= 3'h0; data <= `NFC_CMD_UNLOCK_LO; end
				4'h1: begin kind <= 3'h1; data <= {row[7:5], 5'h00}; end
				4'h2: begin kind <= 3'h1; data <= row[15:8]; end
				4'h3: begin kind <= 3'h0; data <= `NFC_CMD_UNLOCK_HI; end
				4'h4: begin kind <= 3'h1; data <= {row2[7:5], 5'h00}; end
				4'h5: begin kind <= 3'h1; data <= row2[15:8]; end
				default: ;
				endcase
			end
			default: begin
				if (step == 4'h0) begin
					kind <= 3'h0;
					data <= `NFC_CMD_STICKY;
				end
			end
			endcase
		end
	end
endmodule

// ==== logic/nfc_host.v ====
`timescale 1ns/10ps
`include "nfc_defs.vh"
module nfc_host #(
	parameter STROBE_CYC = `NFC_STROBE_CYC,
	parameter WAIT_CYC   = `NFC_BUSY_WAIT_CYC
) (
	input  wire        mclk,
	input  wire        reset_n,
	input  wire        op_valid,
	output wire        op_ready,
	input  wire [2:0]  op_code,
	input  wire [23:0] op_row,
	input  wire [23:0] op_row2,
	input  wire        op_lock_enable,
	output reg         op_done,
	output reg         op_refused,
	output reg  [7:0]  rd_data,
	output reg         rd_valid,
	output reg  [7:0]  op_status,
	output reg         busy,
	output reg         chip_select_n,
	output reg         cmd_latch,
	output reg         addr_latch,
	output reg         input_strobe_n,
	output reg         output_strobe_n,
	output reg         write_protect_n,
	output reg         lock_feature_pin,
	output reg  [7:0]  io_out,
	output reg         io_oe,
	input  wire [7:0]  io_in,
	input  wire        ready_busy_n
);
	// ============================================================
	// States
	localparam S_IDLE  = 6'b000001;
	localparam S_FETCH = 6'b000010;
	localparam S_DECO  = 6'b000100;
	localparam S_LOW   = 6'b001000;
	localparam S_HIGH  = 6'b010000;
	localparam S_WAIT  = 6'b100000;
	// Reads stay low two cycles longer so the pin synchroniser holds settled data
	localparam [15:0] WR_LOW = STROBE_CYC[15:0];
	localparam [15:0] RD_LOW = STROBE_CYC[15:0] + 16'h0002;

	reg  [5:0]  state;
	reg  [2:0]  op;
	reg  [3:0]  step;
	reg  [23:0] row;
	reg  [23:0] row2;
	reg  [15:0] cnt;
	reg  [2:0]  cur_kind;
	reg  [7:0]  cur_data;
	reg         rb_meta;
	reg         rb_sync;
	reg  [7:0]  io_meta;
	reg  [7:0]  io_sync;
	reg         seen_busy;
	wire [2:0]  rom_kind;
	wire [7:0]  rom_data;

	// Requests that would break plane pairing are refused up front
	function plane_clash;
		input [2:0]  code;
		input [23:0] a;
		input [23:0] b;
		begin
			plane_clash = (code == `NFC_OP_COPYBACK) &&
				(a[`NFC_PLANE_BIT] != b[`NFC_PLANE_BIT]);
		end
	endfunction

	assign op_ready = (state == S_IDLE);

	nfc_seq_rom u_rom (
		.mclk    (mclk),
		.reset_n (reset_n),
		.op      (op),
		.step    (step),
		.row     (row),
		.row2    (row2),
		.kind    (rom_kind),
		.data    (rom_data)
	);

	// ============================================================
	// Pin synchronisers
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rb_meta <= 1'b1;
			rb_sync <= 1'b1;
			io_meta <= 8'h00;
			io_sync <= 8'h00;
		end else begin
			rb_meta <= ready_busy_n;
			rb_sync <= rb_meta;
			io_meta <= io_in;
			io_sync <= io_meta;
		end
	end

	// ============================================================
	// Sequencer
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state            <= S_IDLE;
			op               <= 3'h0;
			step             <= 4'h0;
			row              <= 24'h000000;
			row2             <= 24'h000000;
			cnt              <= 16'h0000;
			cur_kind         <= 3'h4;
			cur_data         <= 8'h00;
			seen_busy        <= 1'b0;
			op_done          <= 1'b0;
			op_refused       <= 1'b0;
			rd_data          <= 8'h00;
			rd_valid         <= 1'b0;
			op_status        <= `NFC_ST_RESET_VAL;
			busy             <= 1'b0;
			chip_select_n    <= 1'b1;
			cmd_latch        <= 1'b0;
			addr_latch       <= 1'b0;
			input_strobe_n   <= 1'b1;
			output_strobe_n  <= 1'b1;
			write_protect_n  <= 1'b0;
			lock_feature_pin <= 1'b0;
			io_out           <= 8'h00;
			io_oe            <= 1'b0;
		end else begin
			op_done          <= 1'b0;
			op_refused       <= 1'b0;
			rd_valid         <= 1'b0;
			write_protect_n  <= 1'b1;
			lock_feature_pin <= op_lock_enable;
			case (state)
			S_IDLE: begin
				busy          <= 1'b0;
				chip_select_n <= 1'b1;
				if (op_valid) begin
					if (plane_clash(op_code, op_row, op_row2)) begin
						op_refused <= 1'b1;
					end else begin
						op    <= op_code;
						row   <= op_row;
						row2  <= op_row2;
						step  <= 4'h0;
						busy  <= 1'b1;
						state <= S_FETCH;
					end
				end
			end
			S_FETCH: begin
				state <= S_DECO;
			end
			S_DECO: begin
				cur_kind  <= rom_kind;
				cur_data  <= rom_data;
				cnt       <= 16'h0000;
				seen_busy <= 1'b0;
				chip_select_n <= 1'b0;
				if (rom_kind == 3'h4) begin
					op_done <= 1'b1;
					state   <= S_IDLE;
				end else if (rom_kind == 3'h2) begin
					state <= S_WAIT;
				end else begin
					// Command, address or poll write; read lowers output strobe
					cmd_latch  <= (rom_kind == 3'h0) || (rom_kind == 3'h5);
					addr_latch <= (rom_kind == 3'h1);
					io_out     <= rom_data;
					io_oe      <= (rom_kind != 3'h3);
					if (rom_kind == 3'h3)
						output_strobe_n <= 1'b0;
					else
						input_strobe_n <= 1'b0;
					state <= S_LOW;
				end
			end
			S_LOW: begin
				cnt <= cnt + 16'h0001;
				if (cnt == ((cur_kind == 3'h3) ? RD_LOW : WR_LOW)) begin
					cnt <= 16'h0000;
					if (cur_kind == 3'h3) begin
						// Data held valid by device while strobe low
						rd_data  <= io_sync;
						rd_valid <= 1'b1;
						if (op == `NFC_OP_STATUS)
							op_status <= io_sync;
						output_strobe_n <= 1'b1;
					end else begin
						// Rising edge latches; D0h here starts erase
						input_strobe_n <= 1'b1;
					end
					state <= S_HIGH;
				end
			end
			S_HIGH: begin
				cnt <= cnt + 16'h0001;
				if (cnt == STROBE_CYC[15:0]) begin
					cmd_latch  <= 1'b0;
					addr_latch <= 1'b0;
					io_oe      <= 1'b0;
					cnt        <= 16'h0000;
					if (cur_kind == 3'h5)
						state <= S_WAIT;
					else begin
						step  <= step + 4'h1;
						state <= S_FETCH;
					end
				end
			end
			S_WAIT: begin
				// Allow busy to appear, then wait for ready
				if (cnt != WAIT_CYC[15:0])
					cnt <= cnt + 16'h0001;
				if (!rb_sync)
					seen_busy <= 1'b1;
				if (rb_sync && (seen_busy || cnt == WAIT_CYC[15:0])) begin
					if (cur_kind == 3'h5) begin
						// Poll status once ready; fail bit
						op    <= `NFC_OP_STATUS;
						step  <= 4'h1;
						state <= S_FETCH;
					end else begin
						step  <= step + 4'h1;
						state <= S_FETCH;
					end
				end
			end
			default: state <= S_IDLE;
			endcase
		end
	end
endmodule

// ==== testbench/nfc_host_monitor.sv ====
`timescale 1ns/10ps
// ============================================================
// Handshake and pin checks on the host controller
module nfc_host_monitor (
	input wire        mclk,
	input wire        reset_n,
	input wire        op_valid,
	input wire        op_ready,
	input wire [2:0]  op_code,
	input wire [23:0] op_row,
	input wire [23:0] op_row2,
	input wire        op_done,
	input wire        op_refused,
	input wire        rd_valid,
	input wire [7:0]  op_status,
	input wire        busy,
	input wire        cmd_latch,
	input wire        addr_latch,
	input wire        input_strobe_n,
	input wire        output_strobe_n,
	input wire        io_oe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Copy-back whose two rows sit in different planes
	wire clash = op_valid && op_ready && op_code == 3'h0 && op_row[5] != op_row2[5];
	take_busy_a: assert property (op_valid && op_ready && !clash |=> busy)
		else $error("no busy after take");
	plane_refuse_a: assert property (clash |=> op_refused)
		else $error("plane clash not refused");
	latch_excl_a: assert property (!(cmd_latch && addr_latch))
		else $error("both latches high");
	strobe_width_a: assert property ($fell(input_strobe_n) |-> !input_strobe_n [*2])
		else $error("input strobe too short");
	read_release_a: assert property (!output_strobe_n |-> !io_oe)
		else $error("bus driven during read");
	status_zero_a: assert property (op_status[5:1] == 5'h00)
		else $error("reserved status bits set");
	read_in_op_a: assert property (rd_valid |-> busy)
		else $error("read byte outside operation");
	done_once_a: assert property (op_done |=> !op_done)
		else $error("done longer than a cycle");
	cover property (op_refused);
	cover property (rd_valid);
	cover property (op_done && op_status[0]);
endmodule

// ==== testbench/nfc_flash_model.sv ====
`timescale 1ns/10ps
// ============================================================
// Behavioural flash device behind the pins
module nfc_flash_model #(
	parameter MAKER_CODE = 8'h5a, // Arbitrary value
	parameter DEV_CODE   = 8'h3c, // Arbitrary value
	parameter BUSY_NS    = 200
) (
	input  wire       chip_select_n,
	input  wire       cmd_latch,
	input  wire       addr_latch,
	input  wire       input_strobe_n,
	input  wire       output_strobe_n,
	input  wire       write_protect_n,
	input  wire       lock_feature_pin,
	input  wire [7:0] io_out,
	input  wire       inject_fail,
	output reg  [7:0] io_in,
	output wire       ready_busy_n
);
	reg  [7:0]  cmd = 8'h00;
	reg  [7:0]  a0, last = 8'h00;
	reg         bsy = 1'b0, fail = 1'b0, lk = 1'b1, tight = 1'b0, idn = 1'b0;
	reg  [15:0] erase_row = 16'h0000;
	integer     acnt = 0, erases = 0, copies = 0, reads = 0, resets = 0;
	event       kick;
	// Open drain with pull-up: released means high
	assign ready_busy_n = bsy ? 1'b0 : 1'b1;
	always @(kick) begin
		bsy = 1'b1;
		#BUSY_NS bsy = 1'b0;
	end
	// Commands and addresses land on the rising input strobe
	always @(posedge input_strobe_n) begin
		if (!chip_select_n && cmd_latch) begin
			if (io_out == 8'hff && cmd != 8'hff) begin
				fail = 1'b0;
				resets = resets + 1;
				->kick;
			end
			if (io_out == 8'hd0 && cmd == 8'h60) begin
				if (!(lock_feature_pin && lk)) erases = erases + 1;
				fail = inject_fail;
				->kick;
			end
			if (io_out == 8'h2a) lk = 1'b1;
			if (io_out == 8'h2c && lk) tight = 1'b1;
			cmd = io_out;
			acnt = 0;
			idn = 1'b0;
		end else if (!chip_select_n && addr_latch) begin
			acnt = acnt + 1;
			if (acnt == 1) a0 = io_out;
			if (cmd == 8'h60 && acnt == 2) erase_row = {io_out, a0} & 16'hffe0;
			if (cmd == 8'h24 && acnt == 2 && !tight) lk = 1'b0;
			if (cmd == 8'h00 && acnt == 3) begin
				reads = reads + 1;
				->kick;
			end
			if (cmd == 8'h8a && acnt == 3) begin
				copies = copies + 1;
				fail = inject_fail;
				->kick;
			end
		end
	end
	// Second ID read gives the device code
	always @(posedge output_strobe_n) begin
		last = io_in;
		idn = 1'b1;
	end
	// Released bus shows the inverse of the last byte, so stale data never matches
	always @* begin
		if (chip_select_n || output_strobe_n) io_in = ~last;
		else if (cmd == 8'h70) io_in = {write_protect_n, !bsy, 5'h00, fail};
		else if (cmd == 8'h90) io_in = idn ? DEV_CODE : MAKER_CODE;
		else io_in = 8'ha5;
	end
endmodule

// ==== testbench/nfc_host_bench.sv ====
`timescale 1ns/10ps
`include "nfc_defs.vh"
`define CHK(a, b) begin checks = checks + 1; if ((a) !== (b)) begin \
	num_errors = num_errors + 1; $display("mismatch at %0t: %h %h", $time, a, b); end end
module nfc_host_bench;
	reg         mclk = 1'b0, reset_n = 1'b0, op_valid = 1'b0, inject_fail = 1'b0;
	reg         op_lock_enable = 1'b1, got_ref = 1'b0;
	reg  [2:0]  op_code = 3'h0;
	reg  [23:0] op_row = 24'h0, op_row2 = 24'h0, r;
	reg  [7:0]  rq[$];
	integer     num_errors = 0, checks = 0, n, i;
	wire        op_ready, op_done, op_refused, rd_valid, busy, chip_select_n, cmd_latch;
	wire        addr_latch, input_strobe_n, output_strobe_n, write_protect_n, io_oe;
	wire        lock_feature_pin, ready_busy_n;
	wire [7:0]  rd_data, op_status, io_out, dev_io;
	// Wire level: the host wins while it drives
	wire [7:0]  io_wire = io_oe ? io_out : dev_io;
	nfc_host #(.STROBE_CYC(1), .WAIT_CYC(1)) nfc_host_i (.mclk(mclk), .reset_n(reset_n),
		.op_valid(op_valid), .op_ready(op_ready), .op_code(op_code), .op_row(op_row),
		.op_row2(op_row2), .op_lock_enable(op_lock_enable), .op_done(op_done),
		.op_refused(op_refused), .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy),
		.op_status(op_status), .chip_select_n(chip_select_n), .cmd_latch(cmd_latch),
		.addr_latch(addr_latch), .input_strobe_n(input_strobe_n), .io_out(io_out),
		.output_strobe_n(output_strobe_n), .write_protect_n(write_protect_n),
		.lock_feature_pin(lock_feature_pin), .io_oe(io_oe), .io_in(io_wire),
		.ready_busy_n(ready_busy_n));
	nfc_flash_model nfc_flash_model_i (.chip_select_n(chip_select_n), .cmd_latch(cmd_latch),
		.addr_latch(addr_latch), .input_strobe_n(input_strobe_n), .io_out(io_wire),
		.output_strobe_n(output_strobe_n), .write_protect_n(write_protect_n),
		.lock_feature_pin(lock_feature_pin), .inject_fail(inject_fail), .io_in(dev_io),
		.ready_busy_n(ready_busy_n));
	always #5 mclk = ~mclk;
	// Pulses stand one cycle, so catch them at every edge
	always @(posedge mclk) begin
		if (rd_valid === 1'b1) rq.push_back(rd_data);
		if (op_refused === 1'b1) got_ref = 1'b1;
	end
	function [15:0] blk(input [23:0] a);
		blk = {a[15:5], 5'h00};
	endfunction
	function [7:0] stat(input f);
		stat = 8'hc0 | {7'h00, f};
	endfunction
	task test_done;
		begin
			$display("errors %0d checks %0d", num_errors, checks);
			if (num_errors == 0 && checks > 0) $display("Finished cleanly");
			else $display("Finished with errors");
			$finish;
		end
	endtask
	// One operation: request for one edge, then bounded wait for its end
	task run_op(input [2:0] c, input [23:0] a, input [23:0] b, input f);
		begin
			@(negedge mclk);
			{op_code, op_row, op_row2, inject_fail, op_valid} = {c, a, b, f, 1'b1};
			rq.delete();
			got_ref = 1'b0;
			@(negedge mclk);
			op_valid = 1'b0;
			n = 0;
			while (op_done !== 1'b1 && !got_ref && n < 3000) begin
				@(posedge mclk);
				#1 n = n + 1;
			end
			if (n >= 3000) num_errors = num_errors + 1;
		end
	endtask
	initial begin
		#900000 num_errors = num_errors + 1;
		test_done;
	end
	initial begin
		n = $urandom(32813);
		repeat (5) @(posedge mclk);
		@(negedge mclk);
		reset_n = 1'b1;
		#1 `CHK(op_status, 8'hc0)
		run_op(`NFC_OP_STATUS, 0, 0, 0);
		`CHK(rq[0], stat(1'b0))
		run_op(`NFC_OP_IDENT, 0, 0, 0);
		`CHK({rq[0], rq[1]}, 16'h5a3c)
		run_op(`NFC_OP_ERASE, 24'h000400, 0, 0);
		`CHK(nfc_flash_model_i.erases, 0)
		run_op(`NFC_OP_UNLOCK, 0, 24'hffffff, 0);
		// Edge rows first, then random ones; the third erase fails
		for (i = 0; i < 6; i = i + 1) begin
			r = i == 0 ? 24'h00001f : i == 1 ? 24'hffffff : 24'($urandom);
			run_op(`NFC_OP_ERASE, r, 0, i == 2);
			`CHK(nfc_flash_model_i.erase_row, blk(r))
			`CHK(op_status, stat(i == 2))
		end
		`CHK(nfc_flash_model_i.erases, 6)
		run_op(`NFC_OP_STATUS, 0, 0, 0);
		`CHK(rq[0], stat(1'b0))
		run_op(`NFC_OP_COPYBACK, r, r ^ 24'h000020, 0);
		`CHK(got_ref, 1'b1)
		run_op(`NFC_OP_COPYBACK, r, r ^ 24'h000400, 0);
		`CHK(nfc_flash_model_i.copies, 1)
		`CHK(nfc_flash_model_i.reads, 1)
		run_op(`NFC_OP_LOCK_ALL, 0, 0, 0);
		run_op(`NFC_OP_STICKY, 0, 0, 0);
		run_op(`NFC_OP_UNLOCK, 0, 24'hffffff, 0);
		run_op(`NFC_OP_ERASE, r, 0, 0);
		`CHK(nfc_flash_model_i.erases, 6)
		// Without the lock pin the same block erases
		@(negedge mclk) op_lock_enable = 1'b0;
		run_op(`NFC_OP_ERASE, r, 0, 0);
		`CHK(nfc_flash_model_i.erases, 7)
		run_op(`NFC_OP_RESET, 0, 0, 0);
		run_op(`NFC_OP_RESET, 0, 0, 0);
		`CHK(nfc_flash_model_i.resets, 1)
		run_op(`NFC_OP_STATUS, 0, 0, 0);
		`CHK(rq[0], 8'hc0)
		test_done;
	end
endmodule
bind nfc_host nfc_host_monitor nfc_host_monitor_i (.mclk(mclk), .reset_n(reset_n),
	.op_valid(op_valid), .op_ready(op_ready), .op_code(op_code), .op_row(op_row),
	.op_row2(op_row2), .op_done(op_done), .op_refused(op_refused), .rd_valid(rd_valid),
	.op_status(op_status), .busy(busy), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
	.input_strobe_n(input_strobe_n), .output_strobe_n(output_strobe_n), .io_oe(io_oe));
